/* File: src/ss_adc_timer.sv */
// Purpose: Digital side of a four-channel single-slope converter
// Assumes: Comparator and sync inputs already synchronous to i_clk_sys
// Notes: Registers on a plain word-indexed port, read data one cycle later
// Function
// - Two-bit mode field picks auxiliary input
// - Four channels convert together, one ramp
// - One shared 12-bit counter times crossings
// - Sync pulse resets ramp, restarts conversion
// - Mode bit 7 selects counter rate
// - Results capture counter when comparator trips
// - Counter saturates at 4095
// - Double update mode halves conversion window
// - Untripped channel reports zero
// - 3-bit trim scales ramp current
// - Trim resets to zero
// - Current sample-hold strobes on sync fall
// - Sync rise marks PWM cycle start
// - Fault shutdown suppresses sync, stops conversions
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
module ss_adc_timer (
  input wire logic i_clk_sys, // 100 MHz system clock
  input wire logic i_reset_n, // Sync reset, active low
  input wire logic [3:0] i_addr, // Register index
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after strobe
  input wire logic i_cycle_sync_pulse, // Sync pulse from PWM timing
  input wire logic i_fault_shutdown_pin, // Fault, active low
  input wire logic [3:0] i_cmp_trip, // Comparators: a, b, sense, aux
  output logic o_ramp_reset, // Holds ramp capacitor discharged
  output logic o_sample_hold_strobe, // Current sample-hold pulse
  output logic o_cycle_start, // PWM cycle start pulse
  output logic [1:0] o_aux_select, // Aux mux select
  output logic [2:0] o_ramp_current_trim // Ramp current code
);
  typedef struct packed {
    logic [15:0] mode_control_reg;
    logic [2:0] trim;
    logic [11:0] count;
    logic [3:0] armed;
    logic [3:0] hit;
    logic [3:0][11:0] live;
    logic [3:0][11:0] result;
    logic sync_d;
    logic gate_d;
    logic ramp_reset;
    logic sh_strobe;
    logic cyc_start;
    logic [1:0] aux_sel;
    logic [31:0] rdata;
    logic [7:0] conv_count;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;
  logic tick;
  logic sync_gated;
  logic sync_fall;
  logic sync_rise;
  logic [3:0] trip_new;

  // Fault shutdown gates the sync at the timer input, so no new conversions
  assign sync_gated = i_cycle_sync_pulse && i_fault_shutdown_pin;
  assign sync_fall = st_ff.gate_d && !sync_gated;
  assign sync_rise = !st_ff.gate_d && sync_gated;

  ss_rate_div u_div (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_fast(st_ff.mode_control_reg[ss_adc_pkg::RATE_BIT]),
    .i_hold(sync_gated),
    .o_tick(tick)
  );

  // All four comparators judged against one counter at once
  genvar g;
  generate
    for (g = 0; g < ss_adc_pkg::NUM_CH; g++) begin : g_trip
      assign trip_new[g] = st_ff.armed[g] && i_cmp_trip[g];
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync_d = i_cycle_sync_pulse;
    nxt_st.gate_d = sync_gated;
    nxt_st.ramp_reset = sync_gated;
    nxt_st.sh_strobe = sync_fall;
    nxt_st.cyc_start = sync_rise;
    if (sync_gated) begin
      // Window restarts each sync, so double update halves it naturally
      nxt_st.count = '0;
      nxt_st.armed = '0;
    end else begin
      if (sync_fall) begin
        nxt_st.armed = 4'hf;
        nxt_st.hit = '0;
      end
      if (tick && st_ff.count != ss_adc_pkg::CNT_MAX) begin
        nxt_st.count = st_ff.count + 12'h001;
      end
    end
    for (int i = 0; i < ss_adc_pkg::NUM_CH; i++) begin
      if (trip_new[i]) begin
        nxt_st.live[i] = st_ff.count;
        nxt_st.hit[i] = 1'b1;
        nxt_st.armed[i] = 1'b0;
      end
      // Publish at end of window; channels that never tripped read zero
      if (sync_rise) begin
        nxt_st.result[i] = st_ff.hit[i] ? st_ff.live[i] : ss_adc_pkg::RESULT_NONE;
      end
    end
    if (sync_rise) begin
      nxt_st.hit = '0;
      nxt_st.conv_count = st_ff.conv_count + 8'h01;
    end
    if (i_wr) begin
      case (i_addr)
        ss_adc_pkg::ADDR_MODE: nxt_st.mode_control_reg = i_wdata[15:0];
        ss_adc_pkg::ADDR_TRIM: nxt_st.trim = i_wdata[2:0];
        default: nxt_st.mode_control_reg = nxt_st.mode_control_reg;
      endcase
    end
    nxt_st.aux_sel = {nxt_st.mode_control_reg[ss_adc_pkg::MUX_HI_BIT],
      nxt_st.mode_control_reg[ss_adc_pkg::MUX_LO_BIT]};
    nxt_st.rdata = ss_adc_pkg::UNMAPPED_READ;
    if (i_rd) begin
      case (i_addr)
        ss_adc_pkg::ADDR_MODE: nxt_st.rdata = {16'h0000, st_ff.mode_control_reg};
        ss_adc_pkg::ADDR_TRIM: nxt_st.rdata = {29'h0000_0000, st_ff.trim};
        ss_adc_pkg::ADDR_RES_A: nxt_st.rdata = {20'h00000, st_ff.result[0]};
        ss_adc_pkg::ADDR_RES_B: nxt_st.rdata = {20'h00000, st_ff.result[1]};
        ss_adc_pkg::ADDR_RES_I: nxt_st.rdata = {20'h00000, st_ff.result[2]};
        ss_adc_pkg::ADDR_RES_X: nxt_st.rdata = {20'h00000, st_ff.result[3]};
        ss_adc_pkg::ADDR_STATUS: nxt_st.rdata = {8'h00, st_ff.conv_count, 3'h0,
          !i_fault_shutdown_pin, st_ff.armed, st_ff.count[11:4]};
        default: nxt_st.rdata = ss_adc_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_ff <= '0;
      st_ff.mode_control_reg <= ss_adc_pkg::MODE_RESET;
      st_ff.trim <= ss_adc_pkg::TRIM_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata;
  assign o_ramp_reset = st_ff.ramp_reset;
  assign o_sample_hold_strobe = st_ff.sh_strobe;
  assign o_cycle_start = st_ff.cyc_start;
  assign o_aux_select = st_ff.aux_sel;
  assign o_ramp_current_trim = st_ff.trim;

  // Checks
  p_trim_reset: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !$past(i_reset_n) |-> st_ff.trim == 3'h0)
    else $error("trim not zero after reset");
  a_trim_reset: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $past(!i_reset_n) |-> o_ramp_current_trim == 3'h0)
    else $error("trim output not zero after reset");
  a_sat: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    st_ff.count == 12'hfff && !sync_gated |=> st_ff.count == 12'hfff)
    else $error("counter wrapped");
  a_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    sync_gated |=> st_ff.count == 12'h000 && st_ff.armed == 4'h0)
    else $error("counter not cleared in sync");
  a_ramp: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    sync_gated |=> o_ramp_reset)
    else $error("ramp not held in reset");
  a_sh: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $fell(sync_gated) |=> o_sample_hold_strobe)
    else $error("sample strobe missing");
  a_fault: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !i_fault_shutdown_pin |=> !o_ramp_reset)
    else $error("sync passed during fault");
  a_mux: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_wr && i_addr == 4'h0 |=> o_aux_select == $past(i_wdata[1:0]))
    else $error("aux select mismatch");
  a_slow: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !st_ff.mode_control_reg[7] && tick |=> !tick)
    else $error("slow rate ticked twice");
  a_cap: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    trip_new[0] |=> st_ff.live[0] == $past(st_ff.count) && !st_ff.armed[0])
    else $error("capture wrong");
  a_zero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    sync_rise && !st_ff.hit[1] |=> st_ff.result[1] == 12'h000)
    else $error("untripped result not zero");
endmodule : ss_adc_timer

/* File: src/ss_adc_pkg.sv */
// Purpose: Shared constants for the single-slope converter timer
// Assumes: 32-bit register port, word indices as addresses
// Notes: Register indices are local choices
package ss_adc_pkg;
  localparam int CNT_W = 12;
  localparam logic [11:0] CNT_MAX = 12'hfff;
  localparam logic [11:0] RESULT_NONE = 12'h000;
  localparam int NUM_CH = 4;
  localparam int TRIM_W = 3;
  localparam logic [2:0] TRIM_RESET = 3'h0;
  localparam int MODE_W = 16;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam int MUX_LO_BIT = 0;
  localparam int MUX_HI_BIT = 1;
  localparam int RATE_BIT = 7;
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_TRIM = 4'h1;
  localparam logic [3:0] ADDR_RES_A = 4'h2;
  localparam logic [3:0] ADDR_RES_B = 4'h3;
  localparam logic [3:0] ADDR_RES_I = 4'h4;
  localparam logic [3:0] ADDR_RES_X = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [1:0] SEL_AUX0 = 2'h0;
  localparam logic [1:0] SEL_AUX1 = 2'h1;
  localparam logic [1:0] SEL_AUX2 = 2'h2;
  localparam logic [1:0] SEL_VREF = 2'h3;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : ss_adc_pkg

/* File: src/ss_rate_div.sv */
// Purpose: Tick enable for the ramp counter
// Assumes: i_clk_sys stands for the core clock; input clock is half of it
// Notes: Fast mode ticks every cycle, slow mode every second cycle
`timescale 1ns/1ns
module ss_rate_div (
  input wire logic i_clk_sys, // System clock
  input wire logic i_reset_n, // Sync reset, active low
  input wire logic i_fast, // Count at core rate
  input wire logic i_hold, // Sync pulse high: realign phase
  output logic o_tick // One-cycle counting enable
);
  typedef struct packed {
    logic phase;
  } div_state_t;
  div_state_t st_ff;
  div_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.phase = i_hold ? 1'b0 : ~st_ff.phase;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Gated by hold so the first count follows the falling edge cleanly
  assign o_tick = !i_hold && (i_fast || st_ff.phase);
endmodule : ss_rate_div

/* File: verif/pwm_sync_model.sv */
// Purpose: PWM timing unit, source of the cycle sync pulse
// Assumes: Period and width counted in system clock cycles
// Notes: Keeps running through faults; the timer does the gating
`timescale 1ns/1ns
module pwm_sync_model (
  input wire logic i_clk_sys, // Clock
  input wire logic i_reset_n, // Sync reset, active low
  input wire logic [15:0] i_period, // Cycles per sync period
  input wire logic [15:0] i_width, // Sync pulse width
  output logic o_sync // Cycle sync pulse
);
  logic [15:0] cnt_ff;
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cnt_ff <= 16'h0000;
      o_sync <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff >= i_period - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
      o_sync <= (cnt_ff < i_width);
    end
  end
endmodule : pwm_sync_model

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the converter timer
// Assumes: Trip driven t cycles after sync seen low gives count t, or t/2 slow
// Notes: Comparators toggle after tripping to probe first capture
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, s1 = 1'b0, s2 = 1'b0;
  logic i_fault_shutdown_pin = 1'b1, i_cycle_sync_pulse, o_ramp_reset;
  logic o_sample_hold_strobe, o_cycle_start;
  logic [3:0] i_addr = 4'h0, i_cmp_trip = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [1:0] o_aux_select;
  logic [2:0] o_ramp_current_trim;
  logic [15:0] per = 16'h03e8;
  int fails = 0, total_checks = 0, cyc = 0, tt[4] = '{0, 0, 0, 0}, ex[4];
  always #5 i_clk_sys = ~i_clk_sys;
  pwm_sync_model pwm_sync_model_i (.i_clk_sys, .i_reset_n, .i_period(per),
    .i_width(16'h0014), .o_sync(i_cycle_sync_pulse));
  ss_adc_timer ss_adc_timer_i (.i_clk_sys, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_cycle_sync_pulse, .i_fault_shutdown_pin, .i_cmp_trip, .o_ramp_reset,
    .o_sample_hold_strobe, .o_cycle_start, .o_aux_select, .o_ramp_current_trim);
  always @(posedge i_clk_sys) begin
    if (i_reset_n) begin
      `CHK("ramp_reset", s1, o_ramp_reset)
      `CHK("sh_strobe", s2 & ~s1, o_sample_hold_strobe)
      `CHK("cycle_start", s1 & ~s2, o_cycle_start)
    end
    s2 = i_reset_n & s1;
    s1 = i_reset_n & i_cycle_sync_pulse & i_fault_shutdown_pin;
  end
  // Comparators: trip, drop, trip again; all clear while sync high
  always @(posedge i_clk_sys) begin
    cyc = i_cycle_sync_pulse ? 0 : cyc + 1;
    for (int k = 0; k < 4; k++)
      if (i_cycle_sync_pulse) i_cmp_trip[k] <= 1'b0;
      else if (tt[k] != 0 && (cyc == tt[k] || cyc == tt[k] + 6)) i_cmp_trip[k] <= 1'b1;
      else if (cyc == tt[k] + 3) i_cmp_trip[k] <= 1'b0;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
    d = o_rdata;
  endtask : rd
  task automatic wait_rise();
    int n = 0;
    while (i_cycle_sync_pulse !== 1'b0 && n < 9000) begin @(posedge i_clk_sys); n++; end
    while (i_cycle_sync_pulse !== 1'b1 && n < 9000) begin @(posedge i_clk_sys); n++; end
    if (n >= 9000) begin fails++; summarize(); end
  endtask : wait_rise
  function automatic int expc(bit fast, int t);
    int e = fast ? t : t / 2;
    return t == 0 ? 0 : (e > 4095 ? 4095 : e);
  endfunction : expc
  // Without upd the previous results must survive (fault case)
  task automatic conv(string nm, bit fast, bit upd, int a, int b, int c, int x);
    logic [31:0] d;
    tt = '{a, b, c, x};
    wr(ss_adc_pkg::ADDR_MODE, {24'h0, fast, 7'h00});
    wait_rise();
    wait_rise();
    repeat (3) @(posedge i_clk_sys);
    for (int k = 0; k < 4; k++) begin
      if (upd) ex[k] = expc(fast, tt[k]);
      rd(ss_adc_pkg::ADDR_RES_A + 4'(k), d);
      `CHK(nm, 12'(ex[k]), d[11:0])
    end
    $display("test %s done", nm);
  endtask : conv
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    fails++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    void'($urandom(88798));
    repeat (20) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(ss_adc_pkg::ADDR_TRIM, d);
    `CHK("trim_rst", ss_adc_pkg::TRIM_RESET, d[2:0])
    `CHK("trim_pin_rst", ss_adc_pkg::TRIM_RESET, o_ramp_current_trim)
    for (int k = 0; k < 8; k++) begin
      wr(ss_adc_pkg::ADDR_TRIM, 32'(k));
      wr(ss_adc_pkg::ADDR_MODE, 32'(k));
      rd(ss_adc_pkg::ADDR_TRIM, d);
      `CHK("trim", 3'(k), d[2:0])
      `CHK("trim_pin", 3'(k), o_ramp_current_trim)
      `CHK("aux_sel", 2'(k), o_aux_select)
    end
    rd(4'h7 + 4'($urandom % 9), d);
    `CHK("unmapped", ss_adc_pkg::UNMAPPED_READ, d)
    $display("test registers done");
    conv("fast", 1'b1, 1'b1, 10 + $urandom % 900, 10 + $urandom % 900, 12, 0);
    conv("slow", 1'b0, 1'b1, 20 + $urandom % 900, 11, 0, 30 + $urandom % 900);
    per <= 16'h1130;
    conv("saturate", 1'b1, 1'b1, 4300, 0, 50, 4094);
    i_fault_shutdown_pin <= 1'b0;
    conv("fault", 1'b1, 1'b0, 100, 200, 300, 400);
    summarize();
  end
endmodule : testbench
